// >>> core/pin_cfg.sv
// pin configuration for one eight-line port: alternate function select,
// direction and three drive-strength selects, where a written one clears that line's other two selects after two cycles
// assumes a classic wishbone master on clk_i and a synchronous reset
// that covers both power-on and the external reset pin
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps

// Function
// - a select bit at one gives its line to the alternate function, at zero to software.
// - the select field is bits 7:0 and the bits above are reserved and read as zero.
// - reset clears the select bits of every ordinary line.
// - test-port lines reset with select set, so the port holding one resets to 0x80.
// - after reset every ordinary line is an input with direction and select both zero.
// - power-on reset and the external reset pin both restore the default selections.
// - writing a low-current drive bit clears that line's mid and high drive bits.
// - drive writes act per line and leave the other lines' drive settings alone.
// - a drive bit cleared as a side effect takes its new value two cycles after the write.
module pin_cfg
	import pin_cfg_pkg::*;
#(
	parameter logic [7:0] ALT_RESET = ALT_RESET_PORT_B
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	input  wire logic [7:0]  gpio_out_i,
	input  wire logic [7:0]  alt_out_i,
	input  wire logic [7:0]  alt_oe_i,
	output logic      [7:0]  pad_out_o,
	output logic      [7:0]  pad_oe_o,
	output logic      [7:0]  alt_function_bits_o,
	output logic      [7:0]  drive_low_bit_o,
	output logic      [7:0]  drive_mid_bit_o,
	output logic      [7:0]  drive_high_bit_o
);

	// ==========================================================
	// storage
	logic [7:0] alt_function_select_reg;
	logic [7:0] direction_reg;
	logic [7:0] drive_low_select_reg;
	logic [7:0] drive_mid_select_reg;
	logic [7:0] drive_high_select_reg;

	// pending sibling clears, two stages deep, so the clear lands on the
	// second edge after the write edge
	logic [7:0] clear_low_pend;
	logic [7:0] clear_mid_pend;
	logic [7:0] clear_high_pend;
	logic [7:0] clear_low_late;
	logic [7:0] clear_mid_late;
	logic [7:0] clear_high_late;

	// one write strobe per register
	logic       wr_alt;
	logic       wr_dir;
	logic       wr_low;
	logic       wr_mid;
	logic       wr_high;

	logic       req;
	logic       wr;
	logic       hit;
	logic [7:0] wdat;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == ALT_FUNCTION_SELECT_OFF) || (a == DIRECTION_OFF)
			|| (a == DRIVE_LOW_OFF) || (a == DRIVE_MID_OFF)
			|| (a == DRIVE_HIGH_OFF);
	endfunction

	// ==========================================================
	// bus decode
	assign req  = cyc_i && stb_i && !ack_o && !err_o;
	assign hit  = mapped(adr_i);
	// only lane 0 carries data; upper lanes are reserved
	assign wr   = req && we_i && hit && sel_i[0];
	assign wdat = dat_i[7:0];

	assign wr_alt  = wr && (adr_i == ALT_FUNCTION_SELECT_OFF);
	assign wr_dir  = wr && (adr_i == DIRECTION_OFF);
	assign wr_low  = wr && (adr_i == DRIVE_LOW_OFF);
	assign wr_mid  = wr && (adr_i == DRIVE_MID_OFF);
	assign wr_high = wr && (adr_i == DRIVE_HIGH_OFF);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end
		else
		begin
			ack_o <= req && hit;
			err_o <= req && !hit;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (req && !we_i)
		begin
			dat_o <= 32'h0000_0000; // reserved bits read zero
			case (adr_i)
				ALT_FUNCTION_SELECT_OFF: dat_o[7:0] <= alt_function_select_reg;
				DIRECTION_OFF:           dat_o[7:0] <= direction_reg;
				DRIVE_LOW_OFF:           dat_o[7:0] <= drive_low_select_reg;
				DRIVE_MID_OFF:           dat_o[7:0] <= drive_mid_select_reg;
				DRIVE_HIGH_OFF:          dat_o[7:0] <= drive_high_select_reg;
				default:                 dat_o[7:0] <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// alternate function select and direction
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			alt_function_select_reg <= ALT_RESET;
		else if (wr_alt)
			alt_function_select_reg <= wdat;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			direction_reg <= DIRECTION_RESET; // inputs after reset
		else if (wr_dir)
			direction_reg <= wdat;
	end

	// ==========================================================
	// drive select: a written one sets its own bit at once; the two
	// siblings clear on the second edge after the write edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clear_low_pend  <= 8'h00;
			clear_mid_pend  <= 8'h00;
			clear_high_pend <= 8'h00;
		end
		else
		begin
			clear_low_pend  <= 8'h00;
			clear_mid_pend  <= 8'h00;
			clear_high_pend <= 8'h00;
			if (wr_low)
			begin
				clear_mid_pend  <= wdat;
				clear_high_pend <= wdat;
			end
			if (wr_mid)
			begin
				clear_low_pend  <= wdat;
				clear_high_pend <= wdat;
			end
			if (wr_high)
			begin
				clear_low_pend  <= wdat;
				clear_mid_pend  <= wdat;
			end
		end
	end

	// second stage: the clear is applied from here, two edges after the write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clear_low_late  <= 8'h00;
			clear_mid_late  <= 8'h00;
			clear_high_late <= 8'h00;
		end
		else
		begin
			clear_low_late  <= clear_low_pend;
			clear_mid_late  <= clear_mid_pend;
			clear_high_late <= clear_high_pend;
		end
	end

	// a one sets, a zero leaves the line unchanged: per-line control,
	// and writing zero never leaves a line with no strength
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			drive_low_select_reg <= DRIVE_LOW_RESET;
		else if (wr_low)
			drive_low_select_reg <= (drive_low_select_reg & ~clear_low_late) | wdat;
		else
			drive_low_select_reg <= drive_low_select_reg & ~clear_low_late;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			drive_mid_select_reg <= DRIVE_MID_RESET;
		else if (wr_mid)
			drive_mid_select_reg <= (drive_mid_select_reg & ~clear_mid_late) | wdat;
		else
			drive_mid_select_reg <= drive_mid_select_reg & ~clear_mid_late;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			drive_high_select_reg <= DRIVE_HIGH_RESET;
		else if (wr_high)
			drive_high_select_reg <= (drive_high_select_reg & ~clear_high_late) | wdat;
		else
			drive_high_select_reg <= drive_high_select_reg & ~clear_high_late;
	end

	// ==========================================================
	// pad outputs; a pending clear and the lower-strength output bits mask stale bits,
	// but after a low write the pad still sees two strengths for one cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			drive_low_bit_o  <= DRIVE_LOW_RESET;
			drive_mid_bit_o  <= DRIVE_MID_RESET;
			drive_high_bit_o <= DRIVE_HIGH_RESET;
		end
		else
		begin
			drive_low_bit_o  <= drive_low_select_reg & ~clear_low_late;
			drive_mid_bit_o  <= drive_mid_select_reg & ~clear_mid_late & ~drive_low_bit_o;
			drive_high_bit_o <= drive_high_select_reg & ~clear_high_late
				& ~drive_low_bit_o & ~drive_mid_bit_o;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pad_out_o           <= 8'h00;
			pad_oe_o            <= 8'h00;
			alt_function_bits_o <= ALT_RESET;
		end
		else
		begin
			alt_function_bits_o <= alt_function_select_reg;
			for (int i = 0; i < LINE_COUNT; i++)
			begin
				if (alt_function_select_reg[i]) // hardware owns the line
				begin
					pad_out_o[i] <= alt_out_i[i];
					pad_oe_o[i]  <= alt_oe_i[i];
				end
				else
				begin
					pad_out_o[i] <= gpio_out_i[i];
					pad_oe_o[i]  <= direction_reg[i];
				end
			end
		end
	end

endmodule

// >>> core/pin_cfg_pkg.sv
// pin configuration package: register map, reset values, field widths
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
package pin_cfg_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [11:0] ALT_FUNCTION_SELECT_OFF = 12'h420;
	localparam logic [11:0] DIRECTION_OFF           = 12'h400;
	localparam logic [11:0] DRIVE_LOW_OFF           = 12'h500;
	localparam logic [11:0] DRIVE_MID_OFF           = 12'h504;
	localparam logic [11:0] DRIVE_HIGH_OFF          = 12'h508;

	// ==========================================================
	// field layout and reset values
	localparam int          LINE_COUNT       = 8;
	localparam logic [7:0]  ALT_RESET_PLAIN  = 8'h00;
	localparam logic [7:0]  ALT_RESET_PORT_B = 8'h80;
	localparam logic [7:0]  ALT_RESET_PORT_C = 8'h0f;
	localparam logic [7:0]  DIRECTION_RESET  = 8'h00;
	localparam logic [7:0]  DRIVE_LOW_RESET  = 8'hff;
	localparam logic [7:0]  DRIVE_MID_RESET  = 8'h00;
	localparam logic [7:0]  DRIVE_HIGH_RESET = 8'h00;

	// ==========================================================
	// timing: side-effect clears land this many cycles after the write
	localparam int          SIBLING_CLEAR_DELAY = 2;

endpackage

// >>> testbench/pin_cfg_asserts.sv
// checker for pin_cfg: bus answers, reset values, pad mux, drive selects
// assumes clk_i with a synchronous active-high rst_i
`timescale 1ns/1ps
module pin_cfg_asserts
	import pin_cfg_pkg::*;
#(
	parameter logic [7:0] ALT_RESET = ALT_RESET_PORT_B
)
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        err_o,
	input wire logic [7:0]  gpio_out_i,
	input wire logic [7:0]  alt_out_i,
	input wire logic [7:0]  alt_oe_i,
	input wire logic [7:0]  pad_out_o,
	input wire logic [7:0]  pad_oe_o,
	input wire logic [7:0]  alt_function_bits_o,
	input wire logic [7:0]  drive_low_bit_o,
	input wire logic [7:0]  drive_mid_bit_o,
	input wire logic [7:0]  drive_high_bit_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ====
	// helpers: overlap is legal only while a sibling clear is in flight
	logic [1:0] quiet;
	wire logic  wr_low = cyc_i && stb_i && we_i && sel_i[0] && adr_i == DRIVE_LOW_OFF && !ack_o;
	wire logic [7:0] l = drive_low_bit_o;
	wire logic [7:0] m = drive_mid_bit_o;
	wire logic [7:0] h = drive_high_bit_o;
	always_ff @(posedge clk_i)
		if (rst_i || ack_o)
			quiet <= 2'h0;
		else if (quiet != 2'h3)
			quiet <= quiet + 2'h1;
	sequence s_calm;
		$stable(alt_function_bits_o) && $stable(gpio_out_i) && $stable(alt_out_i) && $stable(alt_oe_i);
	endsequence
	// ====
	// properties
	property p_pad_mux;
		s_calm [*2] |-> pad_out_o == (alt_function_bits_o & alt_out_i | ~alt_function_bits_o & gpio_out_i);
	endproperty
	a_pad_mux: assert property (p_pad_mux) else $error("pad data not muxed by select");
	property p_pad_oe;
		s_calm [*2] |-> (pad_oe_o & alt_function_bits_o) == (alt_oe_i & alt_function_bits_o);
	endproperty
	a_pad_oe: assert property (p_pad_oe) else $error("pad enable not from alternate");
	property p_upper_zero; dat_o[31:8] == 24'h0; endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("reserved bits not zero");
	property p_reset_vals;
		$fell(rst_i) |-> alt_function_bits_o == ALT_RESET && l == DRIVE_LOW_RESET && (m | h) == 8'h0
			&& (pad_oe_o & ~ALT_RESET) == 8'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
	property p_low_clears;
		wr_low |-> ##2 m == $past(m, 2) ##1 ($past(dat_i, 3) & {24'h0, m | h}) == 32'h0;
	endproperty
	a_low_clears: assert property (p_low_clears) else $error("sibling clear timing");
	property p_exclusive; quiet == 2'h3 |-> (l & m | l & h | m & h) == 8'h0; endproperty
	a_exclusive: assert property (p_exclusive) else $error("two drive strengths set");
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_answer; cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o; endproperty
	a_answer: assert property (p_answer) else $error("no single answer to request");
	c_low_write: cover property (wr_low);
	c_err: cover property (err_o);
	c_alt_drive: cover property (pad_oe_o != 8'h0);
endmodule
bind pin_cfg pin_cfg_asserts #(.ALT_RESET(ALT_RESET)) chk_u (.*);

// >>> testbench/tb.sv
// self-checking bench for pin_cfg over classic wishbone
// assumes the checker file binds itself to the design
`timescale 1ns/1ps
module tb
	import pin_cfg_pkg::*;
;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [11:0] adr_i = 12'h0;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic        ack_o, err_o;
	logic [7:0]  gpio_out_i = 8'h0, alt_out_i = 8'h0, alt_oe_i = 8'h0, pad_out_o, pad_oe_o;
	logic [7:0]  alt_function_bits_o, drive_low_bit_o, drive_mid_bit_o, drive_high_bit_o;
	logic [32:0] exp_q[$];
	logic [7:0]  r, s, v;
	int          mismatches = 0, comparisons = 0;
	pin_cfg dut_u (.*);
	initial
		forever #25 clk_i = ~clk_i;
	// ====
	// checking and bus tasks
	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] want);
		comparisons++;
		if (seen !== want)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task automatic test_done();
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// no fixed latency assumed: wait on ack or err, bounded
	task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] b,
		input logic [31:0] d, input logic [32:0] e);
		int n;
		n = 0;
		if (!w)
			exp_q.push_back(e);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= b;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (!(ack_o || err_o) && n < 20);
		if (n >= 20)
		begin
			mismatches++;
			test_done();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 4'hf, 32'h0, {25'h0, e});
	endtask
	task automatic reset_vals();
		rd(ALT_FUNCTION_SELECT_OFF, ALT_RESET_PORT_B);
		rd(DIRECTION_OFF, DIRECTION_RESET);
		rd(DRIVE_LOW_OFF, DRIVE_LOW_RESET);
		rd(DRIVE_MID_OFF, DRIVE_MID_RESET);
	endtask
	always @(posedge clk_i)
		if ((ack_o || err_o) && cyc_i && !we_i)
			chk("read", {err_o, err_o ? 32'h0 : dat_o}, exp_q.pop_front());
	// ====
	// main sequence
	initial
	begin
		r = $urandom(75);
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		reset_vals();
		r = $urandom;
		bus(1'b1, DRIVE_MID_OFF, 4'hf, {24'h0, r}, 33'h0);
		rd(DRIVE_LOW_OFF, ~r);
		s = $urandom;
		bus(1'b1, DRIVE_LOW_OFF, 4'hf, {24'h0, s}, 33'h0);
		rd(DRIVE_LOW_OFF, ~r | s);
		rd(DRIVE_MID_OFF, r & ~s);
		chk("drive", {9'h0, drive_high_bit_o, drive_mid_bit_o, drive_low_bit_o}, {17'h0, r & ~s, ~r | s});
		bus(1'b1, DRIVE_HIGH_OFF, 4'he, 32'hff, 33'h0);
		rd(DRIVE_HIGH_OFF, 8'h00);
		v = $urandom;
		bus(1'b1, ALT_FUNCTION_SELECT_OFF, 4'hf, {24'h0, v}, 33'h0);
		rd(ALT_FUNCTION_SELECT_OFF, v);
		chk("alt", {25'h0, alt_function_bits_o}, {25'h0, v});
		gpio_out_i <= $urandom;
		alt_out_i <= $urandom;
		alt_oe_i <= $urandom;
		repeat (4) @(posedge clk_i);
		chk("pad", {25'h0, pad_out_o}, {25'h0, v & alt_out_i | ~v & gpio_out_i});
		chk("oe", {25'h0, pad_oe_o & v}, {25'h0, alt_oe_i & v});
		bus(1'b0, 12'h424, 4'hf, 32'h0, {1'b1, 32'h0});
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		reset_vals();
		test_done();
	end
endmodule
